/* File: src/rbdn_pkg.sv */
package rbdn_pkg;
  localparam int AXI_AW = 14;
  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_CMD         = 12'h0C0;
  localparam logic [11:0] IDX_CFG         = 12'h0C1;
  localparam logic [11:0] IDX_STATUS      = 12'h0C2;
  localparam logic [11:0] IDX_BUFLEN      = 12'h0C3;
  localparam logic [11:0] IDX_NOTIFY      = 12'h0C4;
  localparam logic [11:0] IDX_AVAIL_BYTES = 12'h0C8;
  localparam logic [11:0] IDX_AVAIL_POS   = 12'h0C9;
  localparam logic [11:0] IDX_RELEASE     = 12'h0CA;
  localparam logic [11:0] IDX_IRQ_STAT    = 12'h0CC;
  localparam logic [11:0] IDX_IRQ_MASK    = 12'h0CD;
  localparam int CMD_START  = 0;
  localparam int CMD_STOP   = 1;
  localparam int CFG_DIR    = 0;
  localparam int CFG_CH_LSB = 4;
  localparam int EV_BLOCK   = 0;
  localparam int EV_OVER    = 1;
  localparam int EV_UNDER   = 2;
  localparam logic [31:0] BUFLEN_RST = 32'h0001_0000;
  localparam logic [31:0] NOTIFY_RST = 32'h0000_1000;
  localparam logic [3:0]  CHMASK_RST = 4'h1;
  localparam logic [31:0] BEAT_BYTES = 32'h0000_0004;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef logic [3:0][15:0] rbdn_frame_t;
  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [31:0] data;
  } rbdn_dreq_t;
  typedef struct packed {
    logic [1:0]      last;
    logic [3:0][1:0] ord;
  } rbdn_order_t;

  function automatic logic [AXI_AW-1:0] rbdn_addr(input logic [11:0] idx);
    return {idx, 2'b00};
  endfunction

  function automatic logic rbdn_mapped(input logic [AXI_AW-1:0] a);
    logic [11:0] i;
    i = a[AXI_AW-1:2];
    return (a[1:0] == 2'h0) && ((i >= IDX_CMD && i <= IDX_NOTIFY) ||
      (i >= IDX_AVAIL_BYTES && i <= IDX_RELEASE) ||
      i == IDX_IRQ_STAT || i == IDX_IRQ_MASK);
  endfunction

  function automatic logic [31:0] rbdn_wrap(input logic [31:0] a,
      input logic [31:0] b, input logic [31:0] len);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s >= {1'b0, len}) ? 32'(s - {1'b0, len}) : s[31:0];
  endfunction

  function automatic rbdn_order_t rbdn_order(input logic [3:0] m);
    rbdn_order_t o;
    logic [2:0]  n;
    o = '0;
    n = 3'h0;
    if (m == 4'hF) begin
      o.ord = {2'h3, 2'h1, 2'h2, 2'h0};
      o.last = 2'h3;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (m[i]) begin
          o.ord[n[1:0]] = 2'(i);
          n = n + 3'h1;
        end
      end
      o.last = (n == 3'h0) ? 2'h0 : 2'(n - 3'h1);
    end
    return o;
  endfunction
endpackage

/* File: src/rbdn_axil.sv */
module rbdn_axil import rbdn_pkg::*; (
  input  wire logic              aclk,    // System clock.
  input  wire logic              aresetn, // Synchronous reset, active low.
  input  wire logic              ce,      // Clock enable.
  input  wire logic [AXI_AW-1:0] awaddr,  // Write address.
  input  wire logic              awvalid, // Write address valid.
  output logic                   awready, // Write address ready.
  input  wire logic [31:0]       wdata,   // Write data.
  input  wire logic [3:0]        wstrb,   // Write byte strobes.
  input  wire logic              wvalid,  // Write data valid.
  output logic                   wready,  // Write data ready.
  output logic [1:0]             bresp,   // Write response.
  output logic                   bvalid,  // Write response valid.
  input  wire logic              bready,  // Write response ready.
  input  wire logic [AXI_AW-1:0] araddr,  // Read address.
  input  wire logic              arvalid, // Read address valid.
  output logic                   arready, // Read address ready.
  output logic [31:0]            rdata,   // Read data.
  output logic [1:0]             rresp,   // Read response.
  output logic                   rvalid,  // Read data valid.
  input  wire logic              rready,  // Read data ready.
  output logic                   wr_en,   // Register write pulse.
  output logic [AXI_AW-1:0]      wr_addr, // Register write address.
  output logic [31:0]            wr_data, // Register write data.
  output logic [3:0]             wr_strb, // Register write strobes.
  input  wire logic              wr_err,  // Write address unmapped.
  input  wire logic [31:0]       rd_data, // Read data for araddr.
  input  wire logic              rd_err   // Read address unmapped.
);
  // Both halves of a write are held until the response is taken.
  assign wr_en = ce && !awready && !wready && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        wr_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
        wready  <= 1'b0;
      end
      if (wr_en) begin
        bvalid <= 1'b1;
        bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_data;
        rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule

/* File: src/rbdn_ilv.sv */
module rbdn_ilv import rbdn_pkg::*; (
  input  wire logic         aclk,      // System clock.
  input  wire logic         aresetn,   // Synchronous reset, active low.
  input  wire logic         ce,        // Clock enable.
  input  wire logic         clr,       // Restart at data offset zero.
  input  wire logic [3:0]   chmask,    // Active channels.
  input  wire logic         in_valid,  // Frame of four samples valid.
  input  wire rbdn_frame_t  in_frame,  // One sample per channel.
  output logic              in_ready,  // Frame taken.
  output logic              out_valid, // Word of two samples valid.
  output logic [31:0]       out_word,  // Earlier sample in low half.
  input  wire logic         out_ready  // Word taken.
);
  rbdn_frame_t frame_q;
  logic [1:0]  idx_q;
  logic        half_q;
  logic [15:0] lo_q;
  rbdn_order_t ord;
  logic        go;
  logic [15:0] smp;

  assign ord = rbdn_order(chmask);
  assign smp = frame_q[ord.ord[idx_q]];
  assign go  = !in_ready && (!half_q || !out_valid || out_ready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_q   <= '0;
      idx_q     <= 2'h0;
      half_q    <= 1'b0;
      lo_q      <= 16'h0000;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
      out_word  <= 32'h0000_0000;
    end else if (ce) begin
      if (clr) begin
        idx_q     <= 2'h0;
        half_q    <= 1'b0;
        in_ready  <= 1'b1;
        out_valid <= 1'b0;
      end else begin
        if (out_valid && out_ready) out_valid <= 1'b0;
        if (in_ready && in_valid) begin
          frame_q  <= in_frame;
          in_ready <= 1'b0;
        end
        if (go) begin
          half_q <= !half_q;
          if (half_q) begin
            out_word  <= {smp, lo_q};
            out_valid <= 1'b1;
          end else begin
            lo_q <= smp;
          end
          if (idx_q == ord.last) begin
            idx_q    <= 2'h0;
            in_ready <= 1'b1;
          end else begin
            idx_q <= idx_q + 2'h1;
          end
        end
      end
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_order_four: assert property (ce && !clr && go && half_q &&
      chmask == 4'hF && idx_q == 2'h1 |=>
      out_word == {$past(frame_q[2]), $past(frame_q[0])})
    else $error("four channel word not module interleaved");
  a_two_alt: assert property (ce && !clr && go && half_q &&
      chmask == 4'h5 && idx_q == 2'h1 |=>
      out_word == {$past(frame_q[2]), $past(frame_q[0])})
    else $error("two channel word does not alternate");
endmodule

/* File: src/rbdn_top.sv */
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
module rbdn_top import rbdn_pkg::*; (
  input  wire logic              aclk,          // System clock.
  input  wire logic              aresetn,       // Sync reset, active low.
  input  wire logic              ce,            // Clock enable.
  input  wire logic [AXI_AW-1:0] awaddr,        // AXI write address.
  input  wire logic              awvalid,       // AXI write address valid.
  output logic                   awready,       // AXI write address ready.
  input  wire logic [31:0]       wdata,         // AXI write data.
  input  wire logic [3:0]        wstrb,         // AXI write strobes.
  input  wire logic              wvalid,        // AXI write data valid.
  output logic                   wready,        // AXI write data ready.
  output logic [1:0]             bresp,         // AXI write response.
  output logic                   bvalid,        // AXI write resp valid.
  input  wire logic              bready,        // AXI write resp ready.
  input  wire logic [AXI_AW-1:0] araddr,        // AXI read address.
  input  wire logic              arvalid,       // AXI read address valid.
  output logic                   arready,       // AXI read address ready.
  output logic [31:0]            rdata,         // AXI read data.
  output logic [1:0]             rresp,         // AXI read response.
  output logic                   rvalid,        // AXI read data valid.
  input  wire logic              rready,        // AXI read data ready.
  input  wire logic              fifo_valid,    // On-board frame valid.
  input  wire rbdn_frame_t       fifo_frame,    // Samples of four channels.
  output logic                   fifo_ready,    // Frame taken.
  input  wire logic              fifo_overrun,  // On-board FIFO overrun.
  input  wire logic              fifo_underrun, // On-board FIFO underrun.
  output logic                   dma_req_valid, // Bus master request.
  output rbdn_dreq_t             dma_req,       // Direction, offset, data.
  input  wire logic              dma_req_ready, // Request accepted.
  input  wire logic              dma_rvalid,    // Fetched word valid.
  input  wire logic [31:0]       dma_rdata,     // Fetched word.
  output logic                   play_valid,    // Word for card memory.
  output logic [31:0]            play_data,     // Fetched word, registered.
  output logic                   irq            // Level interrupt.
);
  localparam logic [AXI_AW-1:0] A_CMD    = rbdn_addr(IDX_CMD);
  localparam logic [AXI_AW-1:0] A_CFG    = rbdn_addr(IDX_CFG);
  localparam logic [AXI_AW-1:0] A_STATUS = rbdn_addr(IDX_STATUS);
  localparam logic [AXI_AW-1:0] A_BUFLEN = rbdn_addr(IDX_BUFLEN);
  localparam logic [AXI_AW-1:0] A_NOTIFY = rbdn_addr(IDX_NOTIFY);
  localparam logic [AXI_AW-1:0] A_AVLEN  = rbdn_addr(IDX_AVAIL_BYTES);
  localparam logic [AXI_AW-1:0] A_AVPOS  = rbdn_addr(IDX_AVAIL_POS);
  localparam logic [AXI_AW-1:0] A_REL    = rbdn_addr(IDX_RELEASE);
  localparam logic [AXI_AW-1:0] A_ISTAT  = rbdn_addr(IDX_IRQ_STAT);
  localparam logic [AXI_AW-1:0] A_IMASK  = rbdn_addr(IDX_IRQ_MASK);

  logic              wr_en;
  logic [AXI_AW-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic [31:0]       rd_data;
  logic              rd_err;

  logic        dir_q;
  logic [3:0]  chmask_q;
  logic [31:0] buflen_q;
  logic [31:0] notify_q;
  logic        run_q;
  logic        drain_q;
  logic        over_q;
  logic        under_q;
  logic [31:0] card_release_length_q;
  logic [31:0] filled_q;
  logic [31:0] user_pos_q;
  logic [31:0] card_pos_q;
  logic [31:0] blk_q;
  logic [2:0]  stat_q;
  logic [2:0]  stat_d;
  logic [2:0]  mask_q;
  logic [2:0]  ev;

  logic        ilv_valid;
  logic [31:0] ilv_word;
  logic        ilv_ready;
  logic        cmd_start;
  logic        cmd_stop;
  logic        rel_we;
  logic        cfg_we;
  logic        acc;
  logic        issue;
  logic        ev_blk;
  logic        drain_done;
  logic [31:0] add_beat;
  logic [31:0] add_rel;

  rbdn_axil u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  rbdn_ilv u_ilv (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .clr       (cmd_start),
    .chmask    (chmask_q),
    .in_valid  (fifo_valid),
    .in_frame  (fifo_frame),
    .in_ready  (fifo_ready),
    .out_valid (ilv_valid),
    .out_word  (ilv_word),
    .out_ready (ilv_ready)
  );

  assign wr_err    = !rbdn_mapped(wr_addr);
  assign cmd_start = wr_en && wr_addr == A_CMD && wr_strb[0] &&
                     wr_data[CMD_START];
  assign cmd_stop  = wr_en && wr_addr == A_CMD && wr_strb[0] &&
                     wr_data[CMD_STOP];
  // Geometry is frozen while running so that the ring stays consistent.
  assign cfg_we    = wr_en && !run_q && &wr_strb;
  assign rel_we    = wr_en && wr_addr == A_REL && run_q && &wr_strb;
  assign add_rel   = rel_we ? wr_data : 32'h0000_0000;

  // One request is outstanding at most, and only into released space.
  assign acc       = dma_req_valid && dma_req_ready;
  assign add_beat  = acc ? BEAT_BYTES : 32'h0000_0000;
  assign issue     = run_q && !dma_req_valid && !cmd_stop &&
                     card_release_length_q >= BEAT_BYTES &&
                     (!dir_q || ilv_valid);
  assign ilv_ready = issue && dir_q;
  assign ev_blk    = acc && (blk_q + BEAT_BYTES >= notify_q);
  assign drain_done = drain_q && !fifo_valid && fifo_ready &&
                      !ilv_valid && !dma_req_valid;

  always_comb begin
    rd_err  = !rbdn_mapped(araddr);
    rd_data = 32'h0000_0000;
    unique case (araddr)
      A_CFG:    rd_data = {24'h00_0000, chmask_q, 3'h0, dir_q};
      A_STATUS: rd_data = {28'h000_0000, drain_q, under_q, over_q, run_q};
      A_BUFLEN: rd_data = buflen_q;
      A_NOTIFY: rd_data = notify_q;
      A_AVLEN:  rd_data = filled_q;
      A_AVPOS:  rd_data = user_pos_q;
      A_REL:    rd_data = card_release_length_q;
      A_ISTAT:  rd_data = {29'h0000_0000, stat_q};
      A_IMASK:  rd_data = {29'h0000_0000, mask_q};
      default:  rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q    <= 1'b1;
      chmask_q <= CHMASK_RST;
      buflen_q <= BUFLEN_RST;
      notify_q <= NOTIFY_RST;
    end else if (ce && cfg_we) begin
      if (wr_addr == A_CFG) begin
        dir_q    <= wr_data[CFG_DIR];
        chmask_q <= wr_data[CFG_CH_LSB +: 4];
      end
      if (wr_addr == A_BUFLEN) buflen_q <= wr_data;
      if (wr_addr == A_NOTIFY) notify_q <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q   <= 1'b0;
      drain_q <= 1'b0;
      over_q  <= 1'b0;
      under_q <= 1'b0;
    end else if (ce) begin
      if (cmd_start) begin
        run_q   <= 1'b1;
        drain_q <= 1'b0;
        over_q  <= 1'b0;
        under_q <= 1'b0;
      end else if (cmd_stop) begin
        run_q   <= 1'b0;
        drain_q <= 1'b0;
      end else if (run_q && !dir_q && fifo_underrun) begin
        run_q   <= 1'b0;
        under_q <= 1'b1;
      end else if (run_q && dir_q && fifo_overrun && !drain_q) begin
        drain_q <= 1'b1;
        over_q  <= 1'b1;
      end else if (drain_done) begin
        run_q   <= 1'b0;
        drain_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      card_release_length_q <= 32'h0000_0000;
      filled_q   <= 32'h0000_0000;
      user_pos_q <= 32'h0000_0000;
      card_pos_q <= 32'h0000_0000;
      blk_q      <= 32'h0000_0000;
    end else if (ce) begin
      if (cmd_start) begin
        card_release_length_q <= buflen_q;
        filled_q   <= 32'h0000_0000;
        user_pos_q <= 32'h0000_0000;
        card_pos_q <= 32'h0000_0000;
        blk_q      <= 32'h0000_0000;
      end else begin
        card_release_length_q <= card_release_length_q - add_beat + add_rel;
        filled_q   <= filled_q + add_beat - add_rel;
        if (acc) card_pos_q <= rbdn_wrap(card_pos_q, BEAT_BYTES,
                                         buflen_q);
        if (rel_we) user_pos_q <= rbdn_wrap(user_pos_q, wr_data,
                                            buflen_q);
        if (ev_blk) blk_q <= 32'h0000_0000;
        else blk_q <= blk_q + add_beat;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_req_valid <= 1'b0;
      dma_req       <= '0;
      play_valid    <= 1'b0;
      play_data     <= 32'h0000_0000;
    end else if (ce) begin
      if (acc) dma_req_valid <= 1'b0;
      if (issue) begin
        dma_req_valid <= 1'b1;
        dma_req.write <= dir_q;
        dma_req.addr  <= card_pos_q;
        dma_req.data  <= dir_q ? ilv_word : 32'h0000_0000;
      end
      play_valid <= dma_rvalid && !dir_q;
      if (dma_rvalid && !dir_q) play_data <= dma_rdata;
    end
  end

  assign ev[EV_BLOCK] = ev_blk && !cmd_start;
  assign ev[EV_OVER]  = run_q && dir_q && fifo_overrun && !drain_q;
  assign ev[EV_UNDER] = run_q && !dir_q && fifo_underrun;
  // A new event wins over a clear written in the same cycle.
  assign stat_d = (stat_q & ~((wr_en && wr_addr == A_ISTAT &&
                   wr_strb[0]) ? wr_data[2:0] : 3'h0)) | ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 3'h0;
      mask_q <= 3'h0;
      irq    <= 1'b0;
    end else if (ce) begin
      stat_q <= stat_d;
      if (wr_en && wr_addr == A_IMASK && wr_strb[0])
        mask_q <= wr_data[2:0];
      irq <= |(stat_d & mask_q);
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [31:0] ring_end;
  assign ring_end = rbdn_wrap(user_pos_q, filled_q, buflen_q);

  sequence s_block_done;
    ce && ev_blk && !cmd_start && mask_q[EV_BLOCK];
  endsequence
  sequence s_overrun_seen;
    ce && run_q && dir_q && fifo_overrun && !drain_q && !cmd_start &&
    !cmd_stop;
  endsequence

  a_irq_block: assert property (s_block_done |=> irq)
    else $error("block completed without interrupt");
  a_start_clean: assert property (ce && cmd_start |=>
      filled_q == 32'h0000_0000 && card_release_length_q == buflen_q &&
      user_pos_q == 32'h0000_0000 && run_q)
    else $error("start did not reset counters");
  a_len_sum: assert property (run_q && filled_q <= buflen_q |->
      filled_q + card_release_length_q == buflen_q)
    else $error("user and card lengths do not cover buffer");
  a_ring_pos: assert property (run_q |->
      ring_end == card_pos_q)
    else $error("card position not user position plus length");
  a_pos_range: assert property (run_q |->
      user_pos_q < buflen_q && card_pos_q < buflen_q)
    else $error("position outside buffer");
  a_bg_fill: assert property (ce && issue |=>
      dma_req_valid && dma_req.addr == $past(card_pos_q))
    else $error("available space not transferred");
  a_no_overfill: assert property (dma_req_valid &&
      !$past(dma_req_valid) |-> $past(card_release_length_q) >= BEAT_BYTES)
    else $error("transfer into space not released");
  a_drain_stop: assert property (s_overrun_seen |=>
      drain_q && over_q && stat_q[EV_OVER])
    else $error("overrun not reported while draining");
  a_under_stop: assert property (ce && run_q && !dir_q &&
      fifo_underrun && !cmd_start |=> !run_q ##1 !dma_req_valid ||
      !run_q)
    else $error("underrun did not stop transfer");
endmodule

/* File: testbench/rbdn_host_model.sv */
module rbdn_host_model import rbdn_pkg::*; (
  input  wire logic       aclk,          // System clock.
  input  wire logic       dma_req_valid, // Request from the block.
  input  wire rbdn_dreq_t dma_req,       // Direction, offset, data.
  output logic            dma_req_ready, // Request accepted.
  output logic            dma_rvalid,    // Fetched word valid.
  output logic [31:0]     dma_rdata      // Fetched word.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [64];
  logic [1:0]  slow_q = 2'h0;
  initial begin
    dma_req_ready = 1'b0;
    dma_rvalid    = 1'b0;
    dma_rdata     = 32'h0;
  end
  // One stall in four, so the block meets a slow host as well as a quick one.
  always @(posedge aclk) begin
    slow_q        <= slow_q + 2'h1;
    dma_req_ready <= slow_q != 2'h3;
    dma_rvalid    <= 1'b0;
    dma_rdata     <= ~dma_rdata;
    if (dma_req_valid && dma_req_ready) begin
      if (dma_req.write) begin
        mem[dma_req.addr[7:2]] <= dma_req.data;
      end else begin
        dma_rvalid <= 1'b1;
        dma_rdata  <= mem[dma_req.addr[7:2]];
      end
    end
  end
endmodule

/* File: testbench/ring_buffer_dma_notify_tb.sv */
module ring_buffer_dma_notify_tb import rbdn_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, awvalid = 1'b0;
  logic wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic fifo_valid = 1'b0, fifo_overrun = 1'b0, fifo_underrun = 1'b0;
  logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = 32'h0, rdata, d, dma_rdata, play_data;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, fifo_ready, irq, play_valid;
  logic dma_req_valid, dma_req_ready, dma_rvalid;
  rbdn_dreq_t dma_req;
  rbdn_frame_t fifo_frame = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
  int n_mismatch = 0, checked = 0, cyc = 0, k;
  logic [43:0] rows [7] = '{{IDX_CMD, 32'h0}, {IDX_CFG, 32'h11},
    {IDX_STATUS, 32'h0}, {IDX_BUFLEN, BUFLEN_RST}, {IDX_NOTIFY, NOTIFY_RST},
    {IDX_AVAIL_BYTES, 32'h0}, {IDX_IRQ_MASK, 32'h0}};
  rbdn_top rbdn_top_inst (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .fifo_valid,
    .fifo_frame, .fifo_ready, .fifo_overrun, .fifo_underrun, .dma_req_valid,
    .dma_req, .dma_req_ready, .dma_rvalid, .dma_rdata, .play_valid,
    .play_data, .irq);
  rbdn_host_model rbdn_host_model_inst (.aclk, .dma_req_valid, .dma_req,
    .dma_req_ready, .dma_rvalid, .dma_rdata);
  always #5 aclk = ~aclk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic axw(input logic [11:0] i, input logic [31:0] v);
    awaddr <= {i, 2'h0};
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask
  task automatic axr(input logic [11:0] i);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
  task automatic rdchk(input logic [11:0] i, input logic [31:0] e);
    axr(i);
    chk(d, e);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) rdchk(rows[i][43:32], rows[i][31:0]);
    $display("reset test done");
    rdchk(12'h0C5, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    axw(12'h0C6, 32'h1);
    chk(32'(r), 32'(RESP_SLVERR));
    $display("unmapped test done");
    axw(IDX_BUFLEN, 32'h40);
    axw(IDX_NOTIFY, 32'h10);
    axw(IDX_CFG, 32'hF1);
    axw(IDX_IRQ_MASK, 32'h7);
    axw(IDX_CMD, 32'h1);
    rdchk(IDX_AVAIL_BYTES, 32'h0);
    rdchk(IDX_RELEASE, 32'h40);
    fifo_valid <= 1'b1;
    for (k = 0; k < 300 && irq !== 1'b1; k++) @(posedge aclk);
    chk(32'(irq), 32'h1);
    rdchk(IDX_AVAIL_POS, 32'h0);
    axr(IDX_AVAIL_BYTES);
    chk(32'(d >= 32'h10), 32'h1);
    chk(rbdn_host_model_inst.mem[0], 32'h3333_1111);
    chk(rbdn_host_model_inst.mem[1], 32'h4444_2222);
    for (k = 0; k < 60 && d !== 32'h40; k++) axr(IDX_AVAIL_BYTES);
    chk(d, 32'h40);
    axw(IDX_IRQ_STAT, 32'h1);
    @(posedge aclk);
    chk(32'(irq), 32'h0);
    $display("first block test done");
    axw(IDX_RELEASE, 32'h30);
    rdchk(IDX_AVAIL_POS, 32'h30);
    for (k = 0; k < 60 && d !== 32'h40; k++) axr(IDX_AVAIL_BYTES);
    chk(d, 32'h40);
    axw(IDX_RELEASE, 32'h10);
    rdchk(IDX_AVAIL_POS, 32'h0);
    $display("wrap test done");
    for (k = 0; k < 60 && d !== 32'h40; k++) axr(IDX_AVAIL_BYTES);
    // The on-board memory takes no new frames after an overrun, only drains.
    fifo_overrun <= 1'b1;
    fifo_valid <= 1'b0;
    axw(IDX_RELEASE, 32'h40);
    axr(IDX_STATUS);
    for (k = 0; k < 60 && d[0] !== 1'b0; k++) axr(IDX_STATUS);
    chk(32'(d[1:0]), 32'h2);
    $display("overrun test done");
    axw(IDX_CFG, 32'h51);
    fifo_overrun <= 1'b0;
    fifo_valid <= 1'b1;
    axw(IDX_CMD, 32'h1);
    for (k = 0; k < 60 && d !== 32'h40; k++) axr(IDX_AVAIL_BYTES);
    chk(rbdn_host_model_inst.mem[0], 32'h3333_1111);
    chk(rbdn_host_model_inst.mem[1], 32'h3333_1111);
    $display("two channel test done");
    axw(IDX_CMD, 32'h2);
    axw(IDX_CFG, 32'h10);
    axw(IDX_RELEASE, 32'h40);
    axw(IDX_CMD, 32'h1);
    for (k = 0; k < 60 && play_valid !== 1'b1; k++) @(posedge aclk);
    chk(play_data, 32'h3333_1111);
    fifo_underrun <= 1'b1;
    @(posedge aclk);
    axr(IDX_STATUS);
    chk(32'(d[3:0]), 32'h4);
    $display("host to card test done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(IDX_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
    $display("second reset test done");
    print_verdict();
  end
endmodule
